// file: design/vcrd_decoder.sv
// module: valve command register decoder
`timescale 1ns/1ns

module vcrd_decoder import vcrd_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register preset
    input vcrd_write_t wr,
    // actuator side
    output vcrd_action_t action_q,
    output logic [6:0] position_q,
    output logic [7:0] relay_q,
    output logic emergency_shutdown_q,
    output logic [15:0] arg_q
);
    // ==========================================
    // write strobes
    logic cmd_wr;
    logic arg_wr;
    logic [7:0] hi;
    logic [7:0] lo;
    logic lo_zero;

    assign cmd_wr = wr.valid && (wr.addr == VCRD_ADDR_CMD);
    assign arg_wr = wr.valid && (wr.addr == VCRD_ADDR_ARG);
    assign hi = wr.data[15:8];
    assign lo = wr.data[7:0];
    assign lo_zero = (lo == 8'h00);

    // ==========================================
    // whole-word commands
    logic is_null;
    logic is_open;
    logic is_stop;
    logic is_close;
    logic is_reset;
    logic is_shutdown_start;
    logic is_shutdown_stop;
    logic is_move_en;
    always_comb begin
        is_null = 1'b0;
        is_open = 1'b0;
        is_stop = 1'b0;
        is_close = 1'b0;
        is_reset = 1'b0;
        is_shutdown_start = 1'b0;
        is_shutdown_stop = 1'b0;
        is_move_en = 1'b0;
        if (cmd_wr) begin
            case (wr.data)
                VCRD_CMD_NULL: begin
                    is_null = 1'b1;
                end
                VCRD_CMD_OPEN: begin
                    is_open = 1'b1;
                end
                VCRD_CMD_STOP: begin
                    is_stop = 1'b1;
                end
                VCRD_CMD_CLOSE: begin
                    is_close = 1'b1;
                end
                VCRD_CMD_RESET: begin
                    is_reset = 1'b1;
                end
                VCRD_CMD_SHUTDOWN_START: begin
                    is_shutdown_start = 1'b1;
                end
                VCRD_CMD_SHUTDOWN_STOP: begin
                    is_shutdown_stop = 1'b1;
                end
                VCRD_CMD_MOVE_EN: begin
                    is_move_en = 1'b1;
                end
                default: begin
                    is_null = 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // move requests
    logic arg_ok;
    logic lo_ok;
    logic is_single;
    logic two_step_go;
    logic one_step_go;
    logic move_go;
    logic [6:0] move_target;

    assign arg_ok = (arg_q <= VCRD_POS_MAX);
    assign lo_ok = ({8'h00, lo} <= VCRD_POS_MAX);
    assign is_single = cmd_wr && (hi == VCRD_HI_SINGLE_MOVE);
    // an out-of-range position is dropped whole rather than clipped
    assign two_step_go = is_move_en && arg_ok;
    assign one_step_go = is_single && lo_ok;
    assign move_go = two_step_go || one_step_go;

    always_comb begin
        move_target = VCRD_POS_RST;
        if (one_step_go) begin
            move_target = lo[6:0];
        end else if (two_step_go) begin
            move_target = arg_q[6:0];
        end
    end

    // ==========================================
    // relay commands
    logic engage_band;
    logic disengage_band;
    logic [7:0] engage_idx;
    logic [7:0] disengage_idx;
    logic [7:0] engage;
    logic [7:0] disengage;

    // a relay code with a nonzero low byte is no relay code at all
    assign engage_band = cmd_wr && lo_zero
        && (hi >= VCRD_HI_ENGAGE_1) && (hi <= VCRD_HI_ENGAGE_7);
    assign disengage_band = cmd_wr && lo_zero
        && (hi >= VCRD_HI_DISENGAGE_1) && (hi <= VCRD_HI_DISENGAGE_7);
    assign engage_idx = hi - VCRD_HI_ENGAGE_1;
    assign disengage_idx = hi - VCRD_HI_DISENGAGE_1;
    always_comb begin
        engage = 8'h00;
        disengage = 8'h00;
        for (int k = 0; k < 7; k++) begin
            engage[k] = engage_band && (engage_idx == 8'(k));
            disengage[k] = disengage_band && (disengage_idx == 8'(k));
        end
        engage[7] = cmd_wr && (wr.data == VCRD_CMD_ENGAGE_8);
        disengage[7] = cmd_wr && (wr.data == VCRD_CMD_DISENGAGE_8);
    end

    // ==========================================
    // listed commands
    logic listed;
    logic acts;

    assign listed = is_null || is_open || is_stop || is_close || is_reset
        || is_shutdown_start || is_shutdown_stop || move_go
        || (|engage) || (|disengage);
    assign acts = listed && !is_null;

    // ==========================================
    // argument register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arg_q <= VCRD_ARG_RST;
        end else if (arg_wr) begin
            arg_q <= wr.data;
        end
    end

    // ==========================================
    // action pulses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            action_q <= '0;
        end else begin
            action_q <= '0;
            if (acts) begin
                action_q.open <= is_open;
                action_q.stop <= is_stop;
                action_q.close <= is_close;
                action_q.reset <= is_reset;
                action_q.shutdown_start <= is_shutdown_start;
                action_q.shutdown_stop <= is_shutdown_stop;
                action_q.move <= move_go;
            end
        end
    end

    // ==========================================
    // target position
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            position_q <= VCRD_POS_RST;
        end else if (move_go) begin
            position_q <= move_target;
        end
    end

    // ==========================================
    // relays
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_q <= VCRD_RELAY_RST;
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (engage[k]) begin
                    relay_q[k] <= 1'b1;
                end else if (disengage[k]) begin
                    relay_q[k] <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // shutdown state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            emergency_shutdown_q <= 1'b0;
        end else if (is_shutdown_start) begin
            emergency_shutdown_q <= 1'b1;
        end else if (is_shutdown_stop) begin
            emergency_shutdown_q <= 1'b0;
        end
    end
endmodule

// file: design/vcrd_pkg.sv
// package: command codes, register addresses and carriers for the valve command decoder
package vcrd_pkg;
    // command register values
    localparam logic [15:0] VCRD_CMD_NULL = 16'h0000;
    localparam logic [15:0] VCRD_CMD_OPEN = 16'h0100;
    localparam logic [15:0] VCRD_CMD_STOP = 16'h0200;
    localparam logic [15:0] VCRD_CMD_CLOSE = 16'h0300;
    localparam logic [15:0] VCRD_CMD_RESET = 16'h0400;
    localparam logic [15:0] VCRD_CMD_SHUTDOWN_START = 16'h0500;
    localparam logic [15:0] VCRD_CMD_SHUTDOWN_STOP = 16'h0600;
    localparam logic [7:0] VCRD_HI_ENGAGE_1 = 8'h09;
    localparam logic [7:0] VCRD_HI_ENGAGE_7 = 8'h0F;
    localparam logic [7:0] VCRD_HI_DISENGAGE_1 = 8'h11;
    localparam logic [7:0] VCRD_HI_DISENGAGE_7 = 8'h17;
    localparam logic [15:0] VCRD_CMD_MOVE_EN = 16'h1A00;
    localparam logic [15:0] VCRD_CMD_ENGAGE_8 = 16'h1B00;
    localparam logic [15:0] VCRD_CMD_DISENGAGE_8 = 16'h1C00;
    localparam logic [7:0] VCRD_HI_SINGLE_MOVE = 8'h4B;
    localparam logic [15:0] VCRD_POS_MAX = 16'h0064;
    // register addresses of field unit 50
    localparam logic [15:0] VCRD_ADDR_CMD = 16'h13B9;
    localparam logic [15:0] VCRD_ADDR_ARG = 16'h13BA;
    // reset values
    localparam logic [7:0] VCRD_RELAY_RST = 8'h00;
    localparam logic [6:0] VCRD_POS_RST = 7'h00;
    localparam logic [15:0] VCRD_ARG_RST = 16'h0000;

    // action pulses toward the actuator
    typedef struct packed {
        logic open;
        logic stop;
        logic close;
        logic reset;
        logic shutdown_start;
        logic shutdown_stop;
        logic move;
    } vcrd_action_t;

    // register preset from the bus front end
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } vcrd_write_t;
endpackage

// file: sim/vcrd_asserts.sv
// checker: decoder port assertions
`timescale 1ns/1ns
// ======
// checks
module vcrd_asserts import vcrd_pkg::*; (
    // watched ports
    input wire logic core_clk,
    input wire logic rst_n,
    input vcrd_write_t wr,
    input vcrd_action_t action_q,
    input logic [6:0] position_q,
    input logic [7:0] relay_q,
    input logic emergency_shutdown_q,
    input logic [15:0] arg_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire cmd = wr.valid && wr.addr == VCRD_ADDR_CMD;
    wire [15:0] d = wr.data;
    wire [7:0] lo = wr.data[7:0];
    chk_close_pulse: assert property (cmd && d == VCRD_CMD_CLOSE |=> action_q == 7'h10)
        else $error("close");
    chk_shutdown_level: assert property (cmd && d == VCRD_CMD_SHUTDOWN_START
        |=> emergency_shutdown_q)
        else $error("shutdown");
    chk_relay_one: assert property (cmd && d == 16'h0900 |=> relay_q[0])
        else $error("relay");
    chk_null_quiet: assert property (cmd && d == 16'h0000 |=> !action_q && $stable(relay_q))
        else $error("null");
    chk_arg_store: assert property (wr.valid && wr.addr == VCRD_ADDR_ARG |=> arg_q == $past(d))
        else $error("arg");
    chk_move_two: assert property (cmd && d == VCRD_CMD_MOVE_EN && arg_q <= VCRD_POS_MAX
        |=> action_q.move && position_q == $past(arg_q)) else $error("move");
    chk_single_move: assert property (cmd && d[15:8] == 8'h4B && lo <= 8'h64
        |=> action_q.move && position_q == $past(lo)) else $error("single");
    chk_foreign_addr: assert property (wr.valid && !cmd && wr.addr != VCRD_ADDR_ARG
        |=> !action_q && $stable(relay_q)) else $error("addr");
    chk_unlisted_quiet: assert property (cmd && lo != 8'h00 && d[15:8] != VCRD_HI_SINGLE_MOVE
        |=> !action_q && $stable(relay_q) && $stable(position_q)) else $error("unlisted");
endmodule
bind vcrd_decoder vcrd_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .wr(wr),
    .action_q(action_q), .position_q(position_q), .relay_q(relay_q),
    .emergency_shutdown_q(emergency_shutdown_q), .arg_q(arg_q));

// file: sim/vcrd_decoder_tb.sv
// testbench: valve command decoder
`timescale 1ns/1ns
// ======
// bench
module vcrd_decoder_tb import vcrd_pkg::*; ;
    logic core_clk = 0;
    logic rst_n = 0;
    vcrd_write_t wr;
    vcrd_action_t action_q;
    logic [6:0] position_q;
    logic [7:0] relay_q;
    logic emergency_shutdown_q;
    logic [15:0] arg_q;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rows [13] = '{32'h0100_8000, 32'h0200_4000, 32'h0300_2000, 32'h0400_1000,
        32'h0500_0801, 32'h0600_0400, 32'h0900_0002, 32'h1B00_0102, 32'h0000_0102,
        32'h0150_0102, 32'h1C01_0102, 32'h1C00_0002, 32'h4B65_0002};
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 1000) begin
        err_total++;
        report_and_stop();
    end
    vcrd_host u_host (.core_clk(core_clk), .wr(wr));
    vcrd_decoder u_dut (.core_clk(core_clk), .rst_n(rst_n), .wr(wr), .action_q(action_q),
        .position_q(position_q), .relay_q(relay_q),
        .emergency_shutdown_q(emergency_shutdown_q), .arg_q(arg_q));
    task chk(input logic [39:0] seen, input logic [39:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        chk({action_q, position_q, relay_q, emergency_shutdown_q, arg_q}, 40'h0);
        rst_n = 1;
        foreach (rows[i]) begin
            u_host.put(VCRD_ADDR_CMD, rows[i][31:16]);
            chk({action_q, relay_q, emergency_shutdown_q}, rows[i][15:0]);
        end
        $display("table done");
        for (int i = 0; i < 7; i++) begin
            u_host.put(VCRD_ADDR_CMD, {VCRD_HI_ENGAGE_1 + 8'(i), 8'h00});
            chk(relay_q, 8'h01 << i | 8'h01);
            u_host.put(VCRD_ADDR_CMD, {VCRD_HI_DISENGAGE_1 + 8'(i), 8'h00});
            chk(relay_q, i ? 8'h01 : 8'h00);
            u_host.put(VCRD_ADDR_CMD, 16'h0900);
        end
        $display("relays done");
        u_host.put(VCRD_ADDR_ARG, 16'd50);
        chk(arg_q, 16'd50);
        u_host.put(VCRD_ADDR_CMD, VCRD_CMD_MOVE_EN);
        chk({action_q, position_q}, {7'h01, 7'd50});
        u_host.put(VCRD_ADDR_ARG, 16'd101);
        u_host.put(VCRD_ADDR_CMD, VCRD_CMD_MOVE_EN);
        chk({action_q, position_q}, {7'h00, 7'd50});
        u_host.put(VCRD_ADDR_CMD, 16'd19200 + 16'd100);
        chk({action_q, position_q}, {7'h01, 7'd100});
        u_host.put(16'h13BB, VCRD_CMD_OPEN);
        chk(action_q, 7'h00);
        $display("moves done");
        @(negedge core_clk);
        rst_n = 0;
        #1;
        chk({action_q, position_q, relay_q, emergency_shutdown_q, arg_q}, 40'h0);
        @(negedge core_clk);
        rst_n = 1;
        u_host.put(VCRD_ADDR_CMD, VCRD_CMD_OPEN);
        chk({action_q, relay_q, emergency_shutdown_q}, 16'h8000);
        $display("reset done");
        report_and_stop();
    end
endmodule

// file: sim/vcrd_host.sv
// partner: host presetting decoder registers
`timescale 1ns/1ns
// ======
// host
module vcrd_host import vcrd_pkg::*; (
    // clock
    input wire logic core_clk,
    // preset
    output vcrd_write_t wr
);
    initial wr = '{1'b0, 16'h0000, 16'hFFFF};
    // one single-register preset, then idle with inverted lines
    task put(input logic [15:0] a, input logic [15:0] v);
        @(negedge core_clk);
        wr = '{1'b1, a, v};
        @(negedge core_clk);
        wr = '{1'b0, ~a, ~v};
    endtask
endmodule
